// file: hdl/engine_driver_fault_control.sv
`timescale 1ns/1ns
`default_nettype none
module engine_driver_fault_control #(
  parameter int SHORT_FILTER_CYC = engine_driver_pkg::SHORT_FILTER_CYC,
  parameter int POR_FILTER_CYC   = engine_driver_pkg::POR_FILTER_CYC,
  parameter int RESET_PULSE_CYC  = engine_driver_pkg::RESET_PULSE_CYC,
  parameter int WDOG_W           = engine_driver_pkg::WDOG_W
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  // supply monitors (comparator results)
  input  wire logic              battery_supply_ok,
  input  wire logic              logic_supply_low,
  input  wire logic              battery_overvoltage,
  // command inputs from the controller
  input  wire logic              injector_cmd_in,
  input  wire logic              spark_cmd_in,
  // injector comparators
  input  wire logic              injector_short_det,
  input  wire logic              injector_open_det,
  input  wire logic              injector_over_temp,
  // spark feedback comparators
  input  wire logic              spark_feedback_over,
  input  wire logic              spark_feedback_open,
  // injector outputs
  output logic                   injector_drive_out,
  output logic                   injector_fault_flag,
  // spark outputs
  output logic                   spark_high_drive,
  output logic                   spark_low_drive,
  output logic                   spark_fault_flag,
  // reset pin, open drain
  output logic                   reset_out_level,
  output logic                   reset_out_oe,
  // watchdog preload
  output logic [WDOG_W-1:0]      watchdog_max_load,
  output logic                   watchdog_start
);

  localparam int NSYNC = 10;
  localparam int PCW   = $clog2(POR_FILTER_CYC + 1);
  localparam int RCW   = $clog2(RESET_PULSE_CYC + 1);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;

  assign raw = {battery_supply_ok, logic_supply_low, battery_overvoltage,
                injector_cmd_in, spark_cmd_in, injector_short_det,
                injector_open_det, injector_over_temp,
                spark_feedback_over, spark_feedback_open};

  // first stage is read only by the second
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
    end
  end

  logic bat_ok_s;
  logic vcc_low_s;
  logic ov_s;
  logic inj_cmd_s;
  logic spk_cmd_s;
  logic inj_short_s;
  logic inj_open_s;
  logic inj_temp_s;
  logic spk_over_s;
  logic spk_open_s;

  assign {bat_ok_s, vcc_low_s, ov_s, inj_cmd_s, spk_cmd_s, inj_short_s,
          inj_open_s, inj_temp_s, spk_over_s, spk_open_s} = sync2_q;

  // ****************************************************************
  // command rise detection
  // ****************************************************************
  logic inj_cmd_prev_q;
  logic spk_cmd_prev_q;
  logic inj_rise;
  logic spk_rise;

  // reset value matches the pulled-down idle level: no false rise after reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      inj_cmd_prev_q <= 1'b0;
    end else begin
      inj_cmd_prev_q <= inj_cmd_s;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      spk_cmd_prev_q <= 1'b0;
    end else begin
      spk_cmd_prev_q <= spk_cmd_s;
    end
  end

  assign inj_rise = inj_cmd_s && !inj_cmd_prev_q;
  assign spk_rise = spk_cmd_s && !spk_cmd_prev_q;

  // ****************************************************************
  // power-on filter
  // ****************************************************************
  // supply state flips only after the new level has held a whole window,
  // so a short dip neither ends nor starts a reset; a glitch restarts it
  // trade-off: a real supply loss is seen one window late
  logic [PCW-1:0] por_cnt_q;
  logic           por_ok_q;
  logic           por_flip;

  assign por_flip = (bat_ok_s != por_ok_q)
                    && (por_cnt_q == PCW'(POR_FILTER_CYC - 1));

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      por_cnt_q <= '0;
    end else if (bat_ok_s == por_ok_q || por_flip) begin
      por_cnt_q <= '0;
    end else begin
      por_cnt_q <= por_cnt_q + PCW'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      por_ok_q <= 1'b0;
    end else if (por_flip) begin
      por_ok_q <= bat_ok_s;
    end
  end

  // ****************************************************************
  // device state and reset pulse
  // ****************************************************************
  engine_driver_pkg::dev_state_t state_q;
  logic [RCW-1:0]                rst_cnt_q;
  logic                          reset_cause;
  logic                          pulse_done;
  logic                          release_now;

  assign reset_cause = !por_ok_q || vcc_low_s;
  assign pulse_done  = (rst_cnt_q == RCW'(RESET_PULSE_CYC));
  // the one edge on which the reset pin lets go
  assign release_now = (state_q == engine_driver_pkg::ST_RESET)
                       && !reset_cause && pulse_done;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_cnt_q <= '0;
    end else if (reset_cause) begin
      rst_cnt_q <= '0;
    end else if (state_q == engine_driver_pkg::ST_RESET && !pulse_done) begin
      rst_cnt_q <= rst_cnt_q + RCW'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= engine_driver_pkg::ST_RESET;
    end else begin
      unique case (state_q)
        engine_driver_pkg::ST_RESET: begin
          if (!reset_cause && pulse_done) begin
            state_q <= engine_driver_pkg::ST_NORMAL;
          end
        end
        engine_driver_pkg::ST_NORMAL: begin
          if (reset_cause) begin
            state_q <= engine_driver_pkg::ST_RESET;
          end
        end
      endcase
    end
  end

  // open drain: data always low, the enable does the work
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reset_out_level <= 1'b0;
    end else begin
      reset_out_level <= 1'b0;
    end
  end

  // pin pulled low while in reset; released (high by pull-up) otherwise
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reset_out_oe <= 1'b1;
    end else begin
      reset_out_oe <= (state_q == engine_driver_pkg::ST_RESET) && !release_now;
    end
  end

  // ****************************************************************
  // watchdog preload
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      watchdog_max_load <= WDOG_W'(engine_driver_pkg::WDOG_MAX_LOAD);
    end else begin
      watchdog_max_load <= WDOG_W'(engine_driver_pkg::WDOG_MAX_LOAD);
    end
  end

  // one pulse as the pin releases; the counter itself lives outside
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      watchdog_start <= 1'b0;
    end else begin
      watchdog_start <= release_now;
    end
  end

  // ****************************************************************
  // protected channels
  // ****************************************************************
  logic normal;

  assign normal = (state_q == engine_driver_pkg::ST_NORMAL);

  driver_if inj_ch ();
  driver_if spk_ch ();

  assign inj_ch.cmd       = inj_cmd_s;
  assign inj_ch.cmd_rise  = inj_rise;
  assign inj_ch.short_det = inj_short_s;
  assign inj_ch.open_det  = inj_open_s;
  assign inj_ch.over_temp = inj_temp_s;
  assign inj_ch.over_volt = ov_s;
  assign inj_ch.enable    = normal;

  // feedback comparator sits at a tenth of collector level
  assign spk_ch.cmd       = spk_cmd_s;
  assign spk_ch.cmd_rise  = spk_rise;
  assign spk_ch.short_det = spk_over_s;
  assign spk_ch.open_det  = spk_open_s;
  assign spk_ch.over_temp = 1'b0;
  assign spk_ch.over_volt = ov_s;
  assign spk_ch.enable    = normal;

  fault_channel #(
    .FILTER_CYC (SHORT_FILTER_CYC),
    .HAS_TEMP   (1'b1)
  ) u_injector (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .ch      (inj_ch.ctrl)
  );

  fault_channel #(
    .FILTER_CYC (SHORT_FILTER_CYC),
    .HAS_TEMP   (1'b0)
  ) u_spark (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .ch      (spk_ch.ctrl)
  );

  // ****************************************************************
  // injector output registers
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      injector_drive_out  <= 1'b0;
      injector_fault_flag <= 1'b0;
    end else begin
      injector_drive_out  <= inj_ch.drive;
      injector_fault_flag <= inj_ch.fault;
    end
  end

  // ****************************************************************
  // spark output registers
  // ****************************************************************
  // both sides come from one bit, so they are never on together
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      spark_high_drive    <= 1'b0;
      spark_low_drive     <= 1'b1;
      spark_fault_flag    <= 1'b0;
    end else begin
      spark_high_drive    <= spk_ch.drive;
      spark_low_drive     <= !spk_ch.drive;
      spark_fault_flag    <= spk_ch.fault;
    end
  end

endmodule
`default_nettype wire

// file: hdl/engine_driver_pkg.sv
package engine_driver_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_FREQ_HZ        = 100_000_000;
  // short-to-battery filter, nominal figure in microseconds
  localparam int SHORT_FILTER_US    = 60;
  localparam int SHORT_FILTER_CYC   = SHORT_FILTER_US * (CLK_FREQ_HZ / 1_000_000);
  // power-on deglitch against supply transients, microseconds
  localparam int POR_FILTER_US      = 100;
  localparam int POR_FILTER_CYC     = POR_FILTER_US * (CLK_FREQ_HZ / 1_000_000);
  // reset output low time, microseconds
  localparam int RESET_PULSE_US     = 100;
  localparam int RESET_PULSE_CYC    = RESET_PULSE_US * (CLK_FREQ_HZ / 1_000_000);

  // ****************************************************************
  // watchdog
  // ****************************************************************
  localparam int          WDOG_W         = 24;
  localparam logic [23:0] WDOG_MAX_LOAD  = 24'hFFFFFF;

  // ****************************************************************
  // device states
  // ****************************************************************
  typedef enum logic [0:0] {
    ST_RESET,
    ST_NORMAL
  } dev_state_t;

endpackage

// file: hdl/driver_if.sv
`timescale 1ns/1ns
`default_nettype none
// conditioned signals of one protected output channel
interface driver_if;
  logic cmd;
  logic cmd_rise;
  logic short_det;
  logic open_det;
  logic over_temp;
  logic over_volt;
  logic enable;
  logic drive;
  logic fault;

  modport ctrl (
    input  cmd,
    input  cmd_rise,
    input  short_det,
    input  open_det,
    input  over_temp,
    input  over_volt,
    input  enable,
    output drive,
    output fault
  );
  modport top (
    output cmd,
    output cmd_rise,
    output short_det,
    output open_det,
    output over_temp,
    output over_volt,
    output enable,
    input  drive,
    input  fault
  );
endinterface
`default_nettype wire

// file: hdl/fault_channel.sv
`timescale 1ns/1ns
`default_nettype none
// one protected output: latch-off on short or overvoltage, re-arm on command rise
module fault_channel #(
  parameter int FILTER_CYC = engine_driver_pkg::SHORT_FILTER_CYC,
  parameter bit HAS_TEMP   = 1'b1
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // conditioned channel signals
  driver_if.ctrl    ch
);

  localparam int CW = $clog2(FILTER_CYC + 1);

  logic          latched_q;
  logic          fault_q;
  logic          drive_q;
  logic [CW-1:0] filt_q;
  logic          short_trip;
  logic          temp_hit;
  logic          open_hit;

  assign temp_hit  = HAS_TEMP && ch.over_temp;
  assign open_hit  = !drive_q && !ch.cmd && ch.open_det;
  assign short_trip = (filt_q == CW'(FILTER_CYC));

  // ****************************************************************
  // short filter: drain high while on must persist
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      filt_q <= '0;
    end else if (drive_q && ch.short_det && !short_trip) begin
      filt_q <= filt_q + CW'(1);
    end else if (!(drive_q && ch.short_det)) begin
      filt_q <= '0;
    end
  end

  // ****************************************************************
  // shutoff latch
  // ****************************************************************
  // rise clears unless overvoltage persists; a short still present must trip the filter again; a new trip wins
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      latched_q <= 1'b0;
    end else if (!ch.enable) begin
      latched_q <= 1'b0;
    end else if (short_trip || ch.over_volt) begin
      latched_q <= 1'b1;
    end else if (ch.cmd_rise) begin
      latched_q <= 1'b0;
    end
  end

  // ****************************************************************
  // fault flag
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fault_q <= 1'b0;
    end else if (!ch.enable) begin
      fault_q <= 1'b0;
    end else if (short_trip || ch.over_volt || temp_hit || open_hit) begin
      fault_q <= 1'b1;
    end else if (ch.cmd_rise) begin
      fault_q <= 1'b0;
    end
  end

  // ****************************************************************
  // output drive
  // ****************************************************************
  // temperature gates regardless of command and is not latched
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= ch.enable && ch.cmd && !latched_q && !temp_hit
                 && !short_trip && !ch.over_volt && !(ch.cmd_rise && ch.over_volt);
    end
  end

  assign ch.drive = drive_q;
  assign ch.fault = fault_q;

endmodule
`default_nettype wire

// file: sim/engine_driver_fault_control_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module engine_driver_fault_control_asserts #(
  parameter int WDOG_W = 24
) (
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              resetn,
  // monitors and command
  input wire logic              logic_supply_low,
  input wire logic              battery_overvoltage,
  input wire logic              injector_cmd_in,
  input wire logic              injector_over_temp,
  // drivers and flags
  input wire logic              injector_drive_out,
  input wire logic              injector_fault_flag,
  input wire logic              spark_high_drive,
  input wire logic              spark_low_drive,
  input wire logic              spark_fault_flag,
  // reset pin and watchdog
  input wire logic              reset_out_level,
  input wire logic              reset_out_oe,
  input wire logic [WDOG_W-1:0] watchdog_max_load,
  input wire logic              watchdog_start
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // ****************************************************************
  // assertions
  // ****************************************************************
  spark_pair_a: assert property (spark_low_drive == !spark_high_drive)
    else $error("spark sides not complementary");
  reset_pin_a: assert property (reset_out_level == 1'b0)
    else $error("reset pin data not low");
  uv_reset_a: assert property (logic_supply_low [*6] |-> reset_out_oe)
    else $error("undervoltage without reset");
  reset_off_a: assert property (reset_out_oe [*2] |->
    !injector_drive_out && !spark_high_drive && !injector_fault_flag && !spark_fault_flag)
    else $error("output active in reset state");
  wdog_load_a: assert property (!reset_out_oe |-> watchdog_max_load == {WDOG_W{1'b1}})
    else $error("watchdog preload not maximum");
  start_pulse_a: assert property (watchdog_start |=> !watchdog_start && !reset_out_oe)
    else $error("watchdog start not a release pulse");
  inj_cmd_off_a: assert property (!injector_cmd_in [*6] |-> !injector_drive_out)
    else $error("injector on with command low");
  inj_temp_a: assert property ((injector_over_temp && !reset_out_oe) [*6] |->
    !injector_drive_out && injector_fault_flag)
    else $error("overtemperature not handled");
  ov_off_a: assert property ((battery_overvoltage && !reset_out_oe) [*6] |->
    !injector_drive_out && !spark_high_drive && spark_fault_flag)
    else $error("overvoltage not handled");
  inj_clear_a: assert property ($fell(injector_fault_flag) && !reset_out_oe |->
    $past(injector_cmd_in, 3))
    else $error("injector flag cleared without command");

  // ****************************************************************
  // coverage
  // ****************************************************************
  inj_trip_c: cover property ($rose(injector_fault_flag));
  spk_trip_c: cover property ($rose(spark_fault_flag));
  wd_start_c: cover property (watchdog_start);
endmodule
`default_nettype wire

// file: sim/mcu_model.sv
`timescale 1ns/1ns
`default_nettype none
// controller side: command lines change just after an edge
module mcu_model (
  // clock
  input  wire logic ref_clk,
  // command lines
  output var logic  injector_cmd_in,
  output var logic  spark_cmd_in
);
  initial begin
    injector_cmd_in = 1'b0;
    spark_cmd_in = 1'b0;
  end
  task automatic drive(input logic inj, input logic spk);
    @(posedge ref_clk);
    #1;
    injector_cmd_in = inj;
    spark_cmd_in = spk;
  endtask
  // low level held 9 cycles so the synchroniser sees it before the rise
  task automatic rearm(input logic inj, input logic spk);
    drive(inj ? 1'b0 : injector_cmd_in, spk ? 1'b0 : spark_cmd_in);
    repeat (8) @(posedge ref_clk);
    drive(inj ? 1'b1 : injector_cmd_in, spk ? 1'b1 : spark_cmd_in);
  endtask
endmodule
`default_nettype wire

// file: sim/engine_driver_fault_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module engine_driver_fault_control_tb;
  localparam int SF = 8;
  typedef struct packed {
    logic inj;
    logic spk;
    logic exp_inj;
    logic exp_spk;
  } row_t;
  localparam row_t ROWS [5] = '{4'b0000, 4'b1010, 4'b1111, 4'b0101, 4'b0000};
  logic ref_clk, resetn, supply_ok, uv, ov, ishort, iopen, itemp, sover, sopen;
  logic inj_out, inj_flt, spk_hi, spk_lo, spk_flt, rst_o, rst_oe, wd_start;
  logic [23:0] wd_load;
  wire logic inj_cmd, spk_cmd;
  int failures = 0;
  int n_tests = 0;
  int wd_starts = 0;
  int cycles = 0;
  row_t r;

  mcu_model mcu_model_i (.ref_clk(ref_clk), .injector_cmd_in(inj_cmd), .spark_cmd_in(spk_cmd));
  engine_driver_fault_control #(.SHORT_FILTER_CYC(SF), .POR_FILTER_CYC(4),
      .RESET_PULSE_CYC(4)) engine_driver_fault_control_i (
    .ref_clk(ref_clk), .resetn(resetn), .battery_supply_ok(supply_ok),
    .logic_supply_low(uv), .battery_overvoltage(ov),
    .injector_cmd_in(inj_cmd), .spark_cmd_in(spk_cmd),
    .injector_short_det(ishort), .injector_open_det(iopen),
    .injector_over_temp(itemp), .spark_feedback_over(sover),
    .spark_feedback_open(sopen), .injector_drive_out(inj_out),
    .injector_fault_flag(inj_flt), .spark_high_drive(spk_hi),
    .spark_low_drive(spk_lo), .spark_fault_flag(spk_flt),
    .reset_out_level(rst_o), .reset_out_oe(rst_oe),
    .watchdog_max_load(wd_load), .watchdog_start(wd_start));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (wd_start === 1'b1) wd_starts++;
    cycles++;
    // whole run needs well under 1000 cycles
    if (cycles == 3000) begin
      failures++;
      results();
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_normal();
    int n;
    n = 0;
    while (rst_oe !== 1'b0 && n < 60) begin
      settle(1);
      n++;
    end
    chk(rst_oe, 1'b0);
    // start pulse is counted on the edge after release
    settle(1);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    {resetn, supply_ok, uv, ov, ishort, iopen, itemp, sover, sopen} = 9'h000;
    settle(2);
    chk({inj_out, inj_flt, spk_hi, spk_lo, spk_flt, rst_oe}, 6'h05);
    settle(1);
    resetn = 1'b1;
    settle(20);
    chk(rst_oe, 1'b1);
    supply_ok = 1'b1;
    wait_normal();
    chk(wd_starts, 1);
    chk(wd_load, engine_driver_pkg::WDOG_MAX_LOAD);
    chk(rst_o, 1'b0);
    $display("test power_on done");
    foreach (ROWS[i]) begin
      r = ROWS[i];
      mcu_model_i.drive(r.inj, r.spk);
      settle(8);
      chk({inj_out, spk_hi, spk_lo}, {r.exp_inj, r.exp_spk, !r.exp_spk});
      chk({inj_flt, spk_flt}, 2'b00);
    end
    $display("test rows done");
    mcu_model_i.drive(1'b1, 1'b0);
    settle(8);
    ishort = 1'b1;
    settle(SF);
    chk(inj_out, 1'b1);
    settle(SF + 4);
    chk({inj_out, inj_flt}, 2'b01);
    ishort = 1'b0;
    settle(8);
    chk({inj_out, inj_flt}, 2'b01);
    mcu_model_i.rearm(1'b1, 1'b0);
    settle(8);
    chk({inj_out, inj_flt}, 2'b10);
    $display("test injector_short done");
    mcu_model_i.drive(1'b1, 1'b1);
    settle(8);
    itemp = 1'b1;
    settle(8);
    chk({inj_out, inj_flt, spk_hi}, 3'b011);
    itemp = 1'b0;
    settle(8);
    chk({inj_out, inj_flt}, 2'b11);
    mcu_model_i.rearm(1'b1, 1'b0);
    settle(8);
    chk(inj_flt, 1'b0);
    $display("test over_temp done");
    ov = 1'b1;
    settle(8);
    chk({inj_out, inj_flt, spk_hi, spk_lo, spk_flt}, 5'h0B);
    mcu_model_i.rearm(1'b1, 1'b1);
    settle(8);
    chk({inj_out, spk_hi, inj_flt, spk_flt}, 4'h3);
    ov = 1'b0;
    settle(8);
    chk({inj_out, spk_hi}, 2'b00);
    mcu_model_i.rearm(1'b1, 1'b1);
    settle(8);
    chk({inj_out, inj_flt, spk_hi, spk_flt}, 4'hA);
    $display("test over_volt done");
    sover = 1'b1;
    settle(2 * SF + 8);
    chk({spk_hi, spk_lo, spk_flt}, 3'b011);
    sover = 1'b0;
    settle(8);
    chk(spk_hi, 1'b0);
    mcu_model_i.rearm(1'b0, 1'b1);
    settle(8);
    chk({spk_hi, spk_flt}, 2'b10);
    $display("test spark_overcurrent done");
    mcu_model_i.drive(1'b0, 1'b0);
    settle(8);
    {iopen, sopen} = 2'b11;
    settle(8);
    chk({inj_flt, spk_flt}, 2'b11);
    {iopen, sopen} = 2'b00;
    mcu_model_i.drive(1'b1, 1'b1);
    settle(8);
    chk({inj_flt, spk_flt, inj_out, spk_hi}, 4'h3);
    $display("test open_load done");
    supply_ok = 1'b0;
    settle(2);
    supply_ok = 1'b1;
    settle(8);
    chk({rst_oe, inj_out, spk_hi}, 3'b011);
    $display("test supply_glitch done");
    uv = 1'b1;
    settle(8);
    chk({rst_oe, inj_out, spk_hi, spk_lo}, 4'h9);
    mcu_model_i.drive(1'b0, 1'b0);
    uv = 1'b0;
    wait_normal();
    chk(wd_starts, 2);
    chk({inj_out, spk_hi, inj_flt, spk_flt}, 4'h0);
    $display("test undervoltage done");
    supply_ok = 1'b0;
    settle(10);
    chk({rst_oe, inj_out, spk_hi}, 3'b100);
    supply_ok = 1'b1;
    wait_normal();
    chk(wd_starts, 3);
    $display("test supply_loss done");
    results();
  end
endmodule

bind engine_driver_fault_control engine_driver_fault_control_asserts #(.WDOG_W(WDOG_W))
  engine_driver_fault_control_asserts_i (
  .ref_clk(ref_clk), .resetn(resetn), .logic_supply_low(logic_supply_low),
  .battery_overvoltage(battery_overvoltage), .injector_cmd_in(injector_cmd_in),
  .injector_over_temp(injector_over_temp), .injector_drive_out(injector_drive_out),
  .injector_fault_flag(injector_fault_flag), .spark_high_drive(spark_high_drive),
  .spark_low_drive(spark_low_drive), .spark_fault_flag(spark_fault_flag),
  .reset_out_level(reset_out_level), .reset_out_oe(reset_out_oe),
  .watchdog_max_load(watchdog_max_load), .watchdog_start(watchdog_start));
`default_nettype wire
